//--- rtl/clru_pkg.sv
// Purpose: shared constants and types of the clock and reset unit core
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: register offsets are byte addresses
//
// Contract
// - registers are reached as an APB slave, reads and writes accepted.
// - clocks come from PLL or oscillator; resets from POR, watchdog, software.
// - five PLLs: CPU, near-CPU, memory, media/audio and common.
// - every generated clock has its own software gate.
// - every module has its own independent software reset.
// - module reset asserts on POR, watchdog, thermal, own request or global resets.
// - key 0xfd9 written to first key register asserts first global reset.
// - key 0xea8 written to second key register asserts second global reset.
// - both global resets release by hardware without further software writes.
// - first global reset resets everything, register file and GPIO included; here all module resets drop, the core's own registers keep their values.
// - second global reset spares general register file and GPIO resets.
// - every PLL takes only the 24MHz oscillator as reference.
// - slow and deep slow modes pass the 24MHz oscillator to the output.
// - divider source selector picks any one of the five PLLs.
// - each PLL reports a lock indication once frequency lock is reached.
package clru_pkg;

  localparam int          NUM_PLLS    = 5;
  localparam int          NUM_CLKS    = 32;
  localparam int          NUM_MODULES = 16;
  localparam int          NUM_DIVS    = 4;
  localparam int          SYNC_STAGES = 2;

  // module reset indices that the second global reset spares
  localparam int          MOD_GRF     = 14;
  localparam int          MOD_GPIO    = 15;

  typedef enum logic [2:0] {
    CLRU_PLL_CPU, CLRU_PLL_NEAR_CPU, CLRU_PLL_MEMORY, CLRU_PLL_MEDIA_AUDIO, CLRU_PLL_COMMON
  } clru_pll_e;

  // per-PLL output mode; slow and deep slow pass the oscillator through
  localparam logic [1:0]  MODE_SLOW      = 2'h0;
  localparam logic [1:0]  MODE_NORMAL    = 2'h1;
  localparam logic [1:0]  MODE_DEEP_SLOW = 2'h2;
  localparam int          MODE_W         = 2;

  localparam logic [11:0] OFF_MODE       = 12'h080;
  localparam logic [11:0] OFF_GLB_CNT    = 12'h090;
  localparam logic [11:0] OFF_GLB_ST     = 12'h094;
  localparam logic [11:0] OFF_KEY_SECOND = 12'h098;
  localparam logic [11:0] OFF_KEY_FIRST  = 12'h09c;
  localparam logic [11:0] OFF_DIV_BASE   = 12'h100;
  localparam logic [11:0] OFF_FRAC       = 12'h110;
  localparam logic [11:0] OFF_GATE       = 12'h200;
  localparam logic [11:0] OFF_SOFT_RST   = 12'h300;
  localparam logic [11:0] OFF_LOCK       = 12'h310;

  localparam logic [11:0] KEY_FIRST      = 12'hfd9;
  localparam logic [11:0] KEY_SECOND     = 12'hea8;
  localparam int          KEY_W          = 12;

  localparam logic [15:0] GLB_CNT_RESET  = 16'h0064;
  localparam logic [31:0] GATE_RESET     = 32'hffff_ffff;
  localparam logic [15:0] FRAC_NUM_RESET = 16'h0bb8;
  localparam logic [15:0] FRAC_DEN_RESET = 16'hea60;

  // status bit positions
  localparam int          ST_FIRST  = 0;
  localparam int          ST_SECOND = 1;
  localparam int          ST_WDT    = 2;
  localparam int          ST_TSADC  = 3;
  localparam int          ST_W      = 4;

  // divider word: source in [2:0], divide value in [15:8]
  localparam int          DIV_SRC_LSB = 0;
  localparam int          DIV_SRC_W   = 3;
  localparam int          DIV_VAL_LSB = 8;
  localparam int          DIV_VAL_W   = 8;
  localparam logic [7:0]  DIV_VAL_RESET = 8'h03;

  typedef struct packed {
    logic [DIV_SRC_W-1:0] src;
    logic [DIV_VAL_W-1:0] div;
  } clru_div_s;

  typedef struct packed {
    logic [15:0] num;
    logic [15:0] den;
  } clru_frac_s;

endpackage : clru_pkg

//--- rtl/clru_core.sv
// Purpose: register side, clock control words and reset generation of the clock and reset unit
// Assumes: pclk is the reference clock of all reset outputs; clock cells sit outside
// Notes: glitch-free muxing, gating cells and PLL macros are driven by the control outputs
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module clru_core (
  // clock, reset, enable
  input  wire logic                                     pclk,
  input  wire logic                                     presetn,
  input  wire logic                                     ce,
  // apb slave
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [11:0]                              paddr,
  input  wire logic [31:0]                              pwdata,
  output logic      [31:0]                              prdata,
  output logic                                          pready,
  output logic                                          pslverr,
  // asynchronous reset sources and pll status
  input  wire logic                                     soc_wdt_rst_n,
  input  wire logic                                     soc_tsadc_rst_n,
  input  wire logic [clru_pkg::NUM_PLLS-1:0]            pll_lock_raw,
  // clock control
  output logic      [clru_pkg::NUM_PLLS*clru_pkg::MODE_W-1:0] pll_mode,
  output logic      [clru_pkg::NUM_CLKS-1:0]            clk_gate_en,
  output clru_pkg::clru_div_s [clru_pkg::NUM_DIVS-1:0]  div_ctrl,
  output clru_pkg::clru_frac_s                          frac_ctrl,
  // resets
  output logic      [clru_pkg::NUM_MODULES-1:0]         module_rst_n
);
  import clru_pkg::*;

  logic                         wr_en;
  logic                         setup;
  logic [31:0]                  next_rdata;
  logic                         next_err;
  logic [NUM_PLLS*MODE_W-1:0]   mode_reg;
  logic [15:0]                  glb_cnt_th;
  logic [ST_W-1:0]              glb_st;
  logic [NUM_MODULES-1:0]       soft_rst;
  logic [NUM_PLLS-1:0]          lock_s1;
  logic [NUM_PLLS-1:0]          lock_s2;
  logic                         hw_src_n;
  logic                         hw_s1;
  logic                         hw_s2;
  logic                         wdt_s1;
  logic                         wdt_s2;
  logic                         tsadc_s1;
  logic                         tsadc_s2;
  logic                         first_hit;
  logic                         second_hit;
  logic                         glb_first_n;
  logic                         glb_second_n;
  logic [15:0]                  first_cnt;
  logic [15:0]                  second_cnt;
  logic [NUM_MODULES-1:0]       next_rst_n;
  logic [ST_W-1:0]              st_set;
  logic [11:0]                  div_off;

  // answer on the first enabled edge of a transfer, so a frozen setup edge only delays it
  assign setup = psel & ~pready;
  // the access phase is the only edge at which a write lands
  assign wr_en = ce & psel & penable & pready & pwrite;

  // key compares look at the low key bits only; wrong keys fall through
  assign first_hit  = wr_en & (paddr == OFF_KEY_FIRST) & (pwdata[KEY_W-1:0] == KEY_FIRST);
  assign second_hit = wr_en & (paddr == OFF_KEY_SECOND) & (pwdata[KEY_W-1:0] == KEY_SECOND);

  // apb answer: one access cycle, data and error prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= setup;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    div_off    = paddr - OFF_DIV_BASE;
    if (paddr == OFF_MODE) begin
      next_rdata[NUM_PLLS*MODE_W-1:0] = mode_reg;
    end else if (paddr == OFF_GLB_CNT) begin
      next_rdata[15:0] = glb_cnt_th;
    end else if (paddr == OFF_GLB_ST) begin
      next_rdata[ST_W-1:0] = glb_st;
    end else if (paddr == OFF_KEY_FIRST || paddr == OFF_KEY_SECOND) begin
      next_rdata = 32'h0000_0000;
    end else if (paddr >= OFF_DIV_BASE && paddr < OFF_FRAC && paddr[1:0] == 2'h0) begin
      next_rdata[DIV_SRC_LSB +: DIV_SRC_W] = div_ctrl[div_off[3:2]].src;
      next_rdata[DIV_VAL_LSB +: DIV_VAL_W] = div_ctrl[div_off[3:2]].div;
    end else if (paddr == OFF_FRAC) begin
      next_rdata = {frac_ctrl.num, frac_ctrl.den};
    end else if (paddr == OFF_GATE) begin
      next_rdata = clk_gate_en;
    end else if (paddr == OFF_SOFT_RST) begin
      next_rdata[NUM_MODULES-1:0] = soft_rst;
    end else if (paddr == OFF_LOCK) begin
      next_rdata[NUM_PLLS-1:0] = lock_s2;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
  end

  // pll modes; every reference is the oscillator, bypass passes it straight out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= '0;
    end else if (wr_en && paddr == OFF_MODE) begin
      mode_reg <= pwdata[NUM_PLLS*MODE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_mode <= '0;
    end else if (ce) begin
      pll_mode <= mode_reg;
    end
  end

  // divider words; source picks one of the five pll outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_DIVS; i++) begin
        div_ctrl[i].src <= DIV_SRC_W'(CLRU_PLL_COMMON);
        div_ctrl[i].div <= DIV_VAL_RESET;
      end
    end else if (wr_en && paddr >= OFF_DIV_BASE && paddr < OFF_FRAC && paddr[1:0] == 2'h0) begin
      div_ctrl[div_off[3:2]].src <= pwdata[DIV_SRC_LSB +: DIV_SRC_W];
      div_ctrl[div_off[3:2]].div <= pwdata[DIV_VAL_LSB +: DIV_VAL_W];
    end
  end

  // fractional divider; small ratios are not guarded, software keeps them above the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_ctrl.num <= FRAC_NUM_RESET;
      frac_ctrl.den <= FRAC_DEN_RESET;
    end else if (wr_en && paddr == OFF_FRAC) begin
      frac_ctrl <= pwdata;
    end
  end

  // clock gates, all running after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gate_en <= GATE_RESET;
    end else if (wr_en && paddr == OFF_GATE) begin
      clk_gate_en <= pwdata[NUM_CLKS-1:0];
    end
  end

  // per-module software reset requests, high holds the module in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst <= '0;
    end else if (wr_en && paddr == OFF_SOFT_RST) begin
      soft_rst <= pwdata[NUM_MODULES-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glb_cnt_th <= GLB_CNT_RESET;
    end else if (wr_en && paddr == OFF_GLB_CNT) begin
      glb_cnt_th <= pwdata[15:0];
    end
  end

  // lock indication crosses in from the pll macros
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1 <= '0;
      lock_s2 <= '0;
    end else if (ce) begin
      lock_s1 <= pll_lock_raw;
      lock_s2 <= lock_s1;
    end
  end

  // watchdog and thermal levels for the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_s1   <= 1'b1;
      wdt_s2   <= 1'b1;
      tsadc_s1 <= 1'b1;
      tsadc_s2 <= 1'b1;
    end else if (ce) begin
      wdt_s1   <= soc_wdt_rst_n;
      wdt_s2   <= wdt_s1;
      tsadc_s1 <= soc_tsadc_rst_n;
      tsadc_s2 <= tsadc_s1;
    end
  end

  // global reset pulse counters; a new key while running restarts nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_cnt <= 16'h0000;
    end else if (ce) begin
      if (first_hit && first_cnt == 16'h0000) begin
        first_cnt <= (glb_cnt_th == 16'h0000) ? 16'h0001 : glb_cnt_th;
      end else if (first_cnt != 16'h0000) begin
        first_cnt <= first_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_cnt <= 16'h0000;
    end else if (ce) begin
      if (second_hit && second_cnt == 16'h0000) begin
        second_cnt <= (glb_cnt_th == 16'h0000) ? 16'h0001 : glb_cnt_th;
      end else if (second_cnt != 16'h0000) begin
        second_cnt <= second_cnt - 16'h0001;
      end
    end
  end

  assign glb_first_n  = (first_cnt == 16'h0000);
  assign glb_second_n = (second_cnt == 16'h0000);

  // status: sticky cause bits, write one clears, a new cause wins over the clear
  assign st_set = {~tsadc_s2, ~wdt_s2, ~glb_second_n, ~glb_first_n};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glb_st <= '0;
    end else if (ce) begin
      if (wr_en && paddr == OFF_GLB_ST) begin
        glb_st <= (glb_st & ~pwdata[ST_W-1:0]) | st_set;
      end else begin
        glb_st <= glb_st | st_set;
      end
    end
  end

  // hardware sources assert asynchronously; release is synchronised below
  assign hw_src_n = presetn & soc_wdt_rst_n & soc_tsadc_rst_n;

  always_ff @(posedge pclk or negedge hw_src_n) begin
    if (!hw_src_n) begin
      hw_s1 <= 1'b0;
      hw_s2 <= 1'b0;
    end else if (ce) begin
      hw_s1 <= 1'b1;
      hw_s2 <= hw_s1;
    end
  end

  // register file and gpio keep state through the second global reset
  always_comb begin
    for (int i = 0; i < NUM_MODULES; i++) begin
      next_rst_n[i] = hw_s2 & ~soft_rst[i] & glb_first_n;
      if (i != MOD_GRF && i != MOD_GPIO) begin
        next_rst_n[i] = next_rst_n[i] & glb_second_n;
      end
    end
  end

  // outputs drop at once on a hardware source, all others act at a clock edge
  always_ff @(posedge pclk or negedge hw_src_n) begin
    if (!hw_src_n) begin
      module_rst_n <= '0;
    end else if (ce) begin
      module_rst_n <= next_rst_n;
    end
  end

endmodule : clru_core
`default_nettype wire

//--- dv/clru_core_checker.sv
// Purpose: port-level checks of the clock and reset unit core
// Assumes: ce stays high around key and soft reset writes
// Notes: global pulse length is judged by the bench
`timescale 1ns/100ps
`default_nettype none
module clru_core_checker (
  // clock and reset
  input wire logic                                          pclk,
  input wire logic                                          presetn,
  input wire logic                                          ce,
  // apb
  input wire logic                                          psel,
  input wire logic                                          penable,
  input wire logic                                          pwrite,
  input wire logic [11:0]                                   paddr,
  input wire logic [31:0]                                   pwdata,
  input wire logic [31:0]                                   prdata,
  input wire logic                                          pready,
  input wire logic                                          pslverr,
  // reset sources and controls
  input wire logic                                          soc_wdt_rst_n,
  input wire logic                                          soc_tsadc_rst_n,
  input wire logic [clru_pkg::NUM_PLLS*clru_pkg::MODE_W-1:0] pll_mode,
  input wire logic [clru_pkg::NUM_CLKS-1:0]                 clk_gate_en,
  input wire logic [clru_pkg::NUM_MODULES-1:0]              module_rst_n
);
  import clru_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable && ce;
  wire logic acc   = psel && penable && pready && pwrite && ce;
  // no source holding any module in reset
  wire logic quiet = soc_wdt_rst_n && soc_tsadc_rst_n && (&module_rst_n);

  property p_ready_next; setup |=> pready; endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("pready missing after setup");
  property p_ready_one; pready && ce |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("pready longer than one cycle");
  property p_unmapped; setup && paddr == 12'h400 |=> pslverr && prdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_mode; acc && paddr == OFF_MODE |=> ##1 pll_mode == $past(pwdata[9:0], 2); endproperty
  a_mode: assert property (p_mode)
    else $error("pll mode not taken");
  property p_gate; acc && paddr == OFF_GATE |=> clk_gate_en == $past(pwdata); endproperty
  a_gate: assert property (p_gate)
    else $error("gate enables not taken");
  property p_soft; acc && paddr == OFF_SOFT_RST && quiet |=> ##1 module_rst_n == ~$past(pwdata[15:0], 2);
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset bits wrong");
  property p_first; acc && paddr == OFF_KEY_FIRST && pwdata[11:0] == KEY_FIRST |=> ##1 module_rst_n == 16'h0000;
  endproperty
  a_first: assert property (p_first)
    else $error("first global reset missing");
  property p_second; acc && paddr == OFF_KEY_SECOND && pwdata[11:0] == KEY_SECOND
    |=> ##1 module_rst_n[13:0] == 14'h0000 && $stable(module_rst_n[15:14]); endproperty
  a_second: assert property (p_second)
    else $error("second global reset wrong");
  property p_wrong; acc && quiet && (paddr == OFF_KEY_FIRST && pwdata[11:0] != KEY_FIRST
    || paddr == OFF_KEY_SECOND && pwdata[11:0] != KEY_SECOND) |=> ##1 &module_rst_n; endproperty
  a_wrong: assert property (p_wrong)
    else $error("wrong key caused reset");
  property p_async; !(soc_wdt_rst_n && soc_tsadc_rst_n) |-> module_rst_n == 16'h0000; endproperty
  a_async: assert property (p_async)
    else $error("external reset not passed");
  property p_release; $rose(module_rst_n[0]) |-> $past(soc_wdt_rst_n, 2) && $past(soc_tsadc_rst_n, 2);
  endproperty
  a_release: assert property (p_release)
    else $error("reset released too early");
endmodule : clru_core_checker

bind clru_core clru_core_checker clru_core_checker_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .soc_wdt_rst_n, .soc_tsadc_rst_n, .pll_mode,
  .clk_gate_en, .module_rst_n);
`default_nettype wire

//--- dv/clru_apb_master.sv
// Purpose: apb master standing in for the processor side
// Assumes: one transfer at a time, called after a clock edge
// Notes: released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module clru_apb_master (
  // clock
  input wire logic        pclk,
  // request
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [11:0]     paddr,
  output logic [31:0]     pwdata,
  // answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale values must not look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : clru_apb_master
`default_nettype wire

//--- dv/test_clru_core.sv
// Purpose: directed tests of the clock and reset unit core
// Assumes: global reset length register set to 4
// Notes: ce drops only in its own scenario, and a gate write is issued while it is low
`timescale 1ns/100ps
`default_nettype none
module test_clru_core;
  import clru_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        soc_wdt_rst_n, soc_tsadc_rst_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, clk_gate_en;
  logic [4:0]  pll_lock_raw;
  logic [9:0]  pll_mode;
  logic [15:0] module_rst_n;
  clru_div_s [NUM_DIVS-1:0] div_ctrl;
  clru_frac_s  frac_ctrl;
  int          fail_count, samples_checked;

  clru_core clru_core_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .soc_wdt_rst_n, .soc_tsadc_rst_n, .pll_lock_raw, .pll_mode, .clk_gate_en,
    .div_ctrl, .frac_ctrl, .module_rst_n);
  clru_apb_master clru_apb_master_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    logic e;
    clru_apb_master_i.xfer(w, a, d, r, e);
  endtask : rw

  task automatic settle;
    @(posedge pclk);
    #1;
  endtask : settle

  task automatic t_regs;
    logic [11:0] a[5] = '{OFF_MODE, OFF_GLB_CNT, OFF_GATE, OFF_FRAC, OFF_DIV_BASE};
    logic [31:0] x[5] = '{32'h0000_0000, 32'h0000_0064, 32'hffff_ffff, 32'h0bb8_ea60, 32'h0000_0304};
    logic [31:0] r;
    logic        e;
    foreach (a[i]) begin
      rw(1'b0, a[i], 32'h0000_0000, r);
      chk("reset value", r, x[i]);
    end
    rw(1'b1, OFF_GATE, 32'h0000_0000, r);
    rw(1'b1, OFF_MODE, 32'h0000_0000, r);
    rw(1'b1, OFF_MODE, 32'h0000_0124, r);
    rw(1'b1, OFF_GATE, 32'ha5a5_5a5a, r);
    settle;
    chk("pll_mode", pll_mode, 32'h0000_0124);
    chk("clk_gate_en", clk_gate_en, 32'ha5a5_5a5a);
    // divide value 2 in [15:8], near-cpu pll as source in [2:0]
    rw(1'b1, OFF_DIV_BASE, 32'h0000_0201, r);
    rw(1'b1, OFF_FRAC, 32'h0001_0019, r);
    settle;
    chk("div near", div_ctrl[0].src, CLRU_PLL_NEAR_CPU);
    chk("div value", div_ctrl[0].div, 32'h0000_0002);
    chk("frac_ctrl", frac_ctrl, 32'h0001_0019);
    for (int s = 0; s < NUM_PLLS; s++) begin
      rw(1'b1, OFF_DIV_BASE + 12'h004, 32'h0000_0700 | s, r);
      settle;
      chk("div src", div_ctrl[1].src, s);
    end
    clru_apb_master_i.xfer(1'b0, 12'h400, 32'h0000_0000, r, e);
    chk("unmapped err", e, 32'h0000_0001);
    chk("unmapped data", r, 32'h0000_0000);
  endtask : t_regs

  task automatic t_ce;
    logic [31:0] r;
    @(posedge pclk);
    ce <= 1'b0;
    fork
      rw(1'b1, OFF_GATE, 32'h0000_00ff, r);
      begin
        repeat (6) settle;
        chk("ce freeze", clk_gate_en, 32'ha5a5_5a5a);
        chk("ce stall", pready, 32'h0000_0000);
        @(posedge pclk);
        ce <= 1'b1;
      end
    join
    settle;
    chk("ce resume", clk_gate_en, 32'h0000_00ff);
  endtask : t_ce

  task automatic t_soft;
    logic [31:0] r;
    rw(1'b1, OFF_SOFT_RST, 32'h0000_8001, r);
    settle;
    chk("soft on", module_rst_n, 32'h0000_7ffe);
    rw(1'b1, OFF_SOFT_RST, 32'h0000_0000, r);
    settle;
    chk("soft off", module_rst_n, 32'h0000_ffff);
  endtask : t_soft

  task automatic t_glb(input logic [11:0] a, input logic [31:0] key, input logic [15:0] low, input int st);
    logic [31:0] r;
    int          n = 0;
    rw(1'b1, OFF_GLB_CNT, 32'h0000_0004, r);
    rw(1'b1, a, key ^ 32'h0000_0001, r);
    settle;
    chk("wrong key", module_rst_n, 32'h0000_ffff);
    rw(1'b1, a, key | 32'hffff_f000, r);
    repeat (20) begin
      settle;
      if (module_rst_n === low) n++;
    end
    chk("global length", n, 4);
    chk("global release", module_rst_n, 32'h0000_ffff);
    rw(1'b0, OFF_GLB_ST, 32'h0000_0000, r);
    chk("global status", r, 32'h0000_0001 << st);
    rw(1'b1, OFF_GLB_ST, 32'h0000_000f, r);
  endtask : t_glb

  task automatic t_async(input logic tsadc);
    logic [31:0] r;
    @(posedge pclk);
    if (tsadc) soc_tsadc_rst_n <= 1'b0;
    else soc_wdt_rst_n <= 1'b0;
    #1;
    chk("async assert", module_rst_n, 32'h0000_0000);
    @(posedge pclk);
    soc_tsadc_rst_n <= 1'b1;
    soc_wdt_rst_n <= 1'b1;
    repeat (2) settle;
    chk("sync hold", module_rst_n, 32'h0000_0000);
    settle;
    chk("sync release", module_rst_n, 32'h0000_ffff);
    rw(1'b0, OFF_GLB_ST, 32'h0000_0000, r);
    chk("cause status", r, 32'h0000_0001 << (tsadc ? ST_TSADC : ST_WDT));
    rw(1'b1, OFF_GLB_ST, 32'h0000_000f, r);
  endtask : t_async

  task automatic t_lock;
    logic [31:0] r;
    @(posedge pclk);
    pll_lock_raw <= 5'h15;
    repeat (3) @(posedge pclk);
    rw(1'b0, OFF_LOCK, 32'h0000_0000, r);
    chk("lock", r, 32'h0000_0015);
  endtask : t_lock

  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  initial begin
    #100_000;
    fail_count++;
    end_sim;
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    soc_wdt_rst_n = 1'b1;
    soc_tsadc_rst_n = 1'b1;
    pll_lock_raw = 5'h00;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) settle;
    chk("por release", module_rst_n, 32'h0000_ffff);
    t_regs;
    t_ce;
    t_soft;
    t_glb(OFF_KEY_FIRST, 32'h0000_0fd9, 16'h0000, ST_FIRST);
    t_glb(OFF_KEY_SECOND, 32'h0000_0ea8, 16'hc000, ST_SECOND);
    t_async(1'b0);
    t_async(1'b1);
    t_lock;
    end_sim;
  end
endmodule : test_clru_core
`default_nettype wire
